/* design/ssc_pkg.sv */
// shared constants, types and helpers of the serial side access config block
// Overview of operation
// [RL1] reset clears the whole configuration register to zero.
// [RL2] a one written to the soft-reset bit starts a reset, then clears.
// [RL3] the soft-reset bit always reads as zero.
// [RL4] mode 00: a locked access gets error sync, reads zero, drops writes.
// [RL5] mode 01: a locked access completes quietly, reads zero, drops writes.
// [RL6] mode 10: a locked access is ignored and no sync is driven.
// [RL7] mode 11: locked chip-select cycles long-wait until unlocked, then end.
// [RL8] mode 11: other locked accesses complete, read zero, drop writes.
// [RL9] with the status bit clear, activation status equals the stored bit.
// [RL10] with the status bit set, locked or disabled modules read inactive.
// [RL11] an access to a locked module sets a sticky flag, cleared by one.
// [RL12] reserved bits read as zero and ignore writes.
package ssc_pkg;

    localparam int MOD_W = 3;
    localparam int MOD_CNT = 8;

    // byte addresses of the apb registers
    localparam logic [7:0] CFG_INDEX = 8'h01;
    localparam logic [7:0] ADDR_CFG = {CFG_INDEX[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_ENABLE = 8'h18;

    // configuration field layout
    localparam int CFG_SOFT_RESET_BIT = 7;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_ACT_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h31;

    // event bits of status, clear and enable
    localparam int EVT_W = 2;
    localparam int EVT_VIOLATION = 0;
    localparam int EVT_SOFT_RESET = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        MODE_ERROR_SYNC,
        MODE_QUIET_DONE,
        MODE_IGNORE,
        MODE_WAIT_XCS
    } ssc_mode_t;

    typedef enum logic [1:0]
    {
        SYNC_NONE,
        SYNC_READY,
        SYNC_ERROR,
        SYNC_LONG_WAIT
    } ssc_sync_t;

    typedef struct packed
    {
        logic write;
        logic xcs;
        logic [MOD_W-1:0] module_id;
    } ssc_req_t;

    typedef struct packed
    {
        logic valid;
        ssc_sync_t sync;
        logic forward;
        logic read_zero;
    } ssc_rsp_t;

    function automatic logic bit_at(input logic [MOD_CNT-1:0] vec,
                                    input logic [MOD_W-1:0] idx);
        bit_at = vec[idx];
    endfunction

endpackage

/* design/ssc_lock_resolver.sv */
// decides how one lpc cycle toward a possibly locked module is answered
`timescale 1ns/1ps
module ssc_lock_resolver
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire ssc_req_t req,
    input wire logic [MOD_CNT-1:0] lock_vec,
    input wire ssc_mode_t mode,
    output ssc_rsp_t rsp_q,
    output logic long_wait_q,
    output logic violation_q
);

    typedef enum logic {RS_IDLE, RS_HOLD} ssc_rstate_t;

    ssc_rstate_t state_q, state_d;
    logic [MOD_W-1:0] held_q, held_d;
    ssc_rsp_t rsp_d;
    logic long_wait_d;
    logic violation_d;
    logic locked;

    assign locked = bit_at(lock_vec, req.module_id);

    always_comb
    begin
        state_d = state_q;
        held_d = held_q;
        rsp_d = '{valid: 1'b0, sync: SYNC_NONE, forward: 1'b0,
                  read_zero: 1'b0};
        long_wait_d = long_wait_q;
        violation_d = 1'b0;
        unique case (state_q)
            RS_IDLE:
            begin
                if (req_valid)
                begin
                    held_d = req.module_id;
                    // [RL11] flag locked access
                    violation_d = locked;
                    if (!locked)
                    begin
                        rsp_d = '{1'b1, SYNC_READY, 1'b1, 1'b0};
                    end
                    else
                    begin
                        unique case (mode)
                            // [RL4] error sync, zero
                            MODE_ERROR_SYNC:
                                rsp_d = '{1'b1, SYNC_ERROR, 1'b0, 1'b1};
                            // [RL5] quiet completion
                            MODE_QUIET_DONE:
                                rsp_d = '{1'b1, SYNC_READY, 1'b0, 1'b1};
                            // [RL6] no sync at all
                            MODE_IGNORE:
                                rsp_d = '{1'b1, SYNC_NONE, 1'b0, 1'b0};
                            MODE_WAIT_XCS:
                            begin
                                if (req.xcs)
                                begin
                                    // [RL7] start long waits
                                    state_d = RS_HOLD;
                                    long_wait_d = 1'b1;
                                end
                                else
                                begin
                                    // [RL8] other locked cycles complete
                                    rsp_d = '{1'b1, SYNC_READY, 1'b0, 1'b1};
                                end
                            end
                        endcase
                    end
                end
            end
            RS_HOLD:
            begin
                // [RL7] complete once unlocked
                if (!bit_at(lock_vec, held_q))
                begin
                    state_d = RS_IDLE;
                    long_wait_d = 1'b0;
                    rsp_d = '{1'b1, SYNC_READY, 1'b1, 1'b0};
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= RS_IDLE;
            held_q <= '0;
            rsp_q <= '{1'b0, SYNC_NONE, 1'b0, 1'b0};
            long_wait_q <= 1'b0;
            violation_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            held_q <= held_d;
            rsp_q <= rsp_d;
            long_wait_q <= long_wait_d;
            violation_q <= violation_d;
        end
    end

endmodule

/* design/ssc_top.sv */
// serial side access configuration: apb registers, lock answers, status
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module ssc_top
    import ssc_pkg::*;
#(
    parameter int N_MODULES = MOD_CNT
)
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LPC_REQ_VALID,
    input wire ssc_req_t LPC_REQ,
    output ssc_rsp_t LPC_RSP,
    output logic LPC_LONG_WAIT,
    input wire logic [N_MODULES-1:0] MODULE_LOCK,
    input wire logic [N_MODULES-1:0] FAST_DISABLE,
    input wire logic [N_MODULES-1:0] ACTIVATION_BIT,
    input wire logic [MOD_W-1:0] ACT_QUERY_MODULE,
    output logic ACT_STATUS,
    output logic CONTROLLER_SOFT_RESET,
    output logic IRQ
);

    if (N_MODULES < 1 || N_MODULES > MOD_CNT)
    begin : g_check
        $error("N_MODULES must lie between 1 and MOD_CNT");
    end

    // register state
    logic [1:0] mode_q, mode_d;
    logic act_cfg_q, act_cfg_d;
    logic soft_reset_q, soft_reset_d;
    logic [EVT_W-1:0] status_q, status_d;
    logic [EVT_W-1:0] enable_q, enable_d;
    logic [31:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;
    logic act_status_q, act_status_d;
    logic irq_q, irq_d;

    // bus decode
    logic setup;
    logic wr_en;
    logic rd_en;
    logic hit_cfg;
    logic hit_status;
    logic hit_clear;
    logic hit_enable;
    logic mapped;

    // lock resolver hookup
    logic [MOD_CNT-1:0] lock_ext;
    logic [MOD_CNT-1:0] fdis_ext;
    logic [MOD_CNT-1:0] act_ext;
    logic violation;
    logic [EVT_W-1:0] events;

    assign lock_ext = MOD_CNT'(MODULE_LOCK);
    assign fdis_ext = MOD_CNT'(FAST_DISABLE);
    assign act_ext = MOD_CNT'(ACTIVATION_BIT);

    ssc_lock_resolver u_resolver
    (
        .clk(CORE_CLK),
        .rst(RST),
        .req_valid(LPC_REQ_VALID),
        .req(LPC_REQ),
        .lock_vec(lock_ext),
        .mode(ssc_mode_t'(mode_q)),
        .rsp_q(LPC_RSP),
        .long_wait_q(LPC_LONG_WAIT),
        .violation_q(violation)
    );

    // apb decode: the slave answers in the access cycle itself
    assign setup = PSEL && !PENABLE;
    assign hit_cfg = (PADDR == ADDR_CFG);
    assign hit_status = (PADDR == ADDR_STATUS);
    assign hit_clear = (PADDR == ADDR_CLEAR);
    assign hit_enable = (PADDR == ADDR_ENABLE);
    assign mapped = hit_cfg || hit_status || hit_clear || hit_enable;
    assign wr_en = PSEL && PENABLE && PWRITE && mapped;
    assign rd_en = setup && !PWRITE;

    // configuration register
    always_comb
    begin
        mode_d = mode_q;
        act_cfg_d = act_cfg_q;
        soft_reset_d = 1'b0;
        if (wr_en && hit_cfg)
        begin
            // [RL12] reserved bits dropped
            mode_d = PWDATA[CFG_MODE_LSB +: 2];
            act_cfg_d = PWDATA[CFG_ACT_BIT];
            // [RL2] one-cycle reset start
            soft_reset_d = PWDATA[CFG_SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            // [RL1] register cleared
            mode_q <= CFG_RESET[CFG_MODE_LSB +: 2];
            act_cfg_q <= CFG_RESET[CFG_ACT_BIT];
            soft_reset_q <= CFG_RESET[CFG_SOFT_RESET_BIT];
        end
        else
        begin
            mode_q <= mode_d;
            act_cfg_q <= act_cfg_d;
            soft_reset_q <= soft_reset_d;
        end
    end

    // event status, enable and interrupt
    assign events = {soft_reset_q, violation};

    always_comb
    begin
        status_d = status_q;
        enable_d = enable_q;
        if (wr_en && hit_clear)
        begin
            status_d = status_q & ~PWDATA[EVT_W-1:0];
        end
        // [RL11] set beats clear
        status_d = status_d | events;
        if (wr_en && hit_enable)
        begin
            enable_d = PWDATA[EVT_W-1:0];
        end
        irq_d = |(status_d & enable_d);
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            status_q <= EVT_RESET;
            enable_q <= EVT_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            enable_q <= enable_d;
            irq_q <= irq_d;
        end
    end

    // read data, taken in the setup cycle so it is stable in access
    always_comb
    begin
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        if (setup)
        begin
            rdata_d = '0;
            slverr_d = !mapped;
            if (rd_en && hit_cfg)
            begin
                // [RL3] soft-reset reads zero
                rdata_d[CFG_SOFT_RESET_BIT] = 1'b0;
                rdata_d[CFG_MODE_LSB +: 2] = mode_q;
                rdata_d[CFG_ACT_BIT] = act_cfg_q;
            end
            else if (rd_en && hit_status)
            begin
                rdata_d[EVT_W-1:0] = status_q;
            end
            else if (rd_en && hit_enable)
            begin
                rdata_d[EVT_W-1:0] = enable_q;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_q <= '0;
            slverr_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // activation status as seen from the lpc side
    always_comb
    begin
        // [RL9] stored bit by default
        act_status_d = bit_at(act_ext, ACT_QUERY_MODULE);
        // [RL10] masked when locked or disabled
        if (act_cfg_q && (bit_at(lock_ext, ACT_QUERY_MODULE) ||
                          bit_at(fdis_ext, ACT_QUERY_MODULE)))
        begin
            act_status_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            act_status_q <= 1'b0;
        end
        else
        begin
            act_status_q <= act_status_d;
        end
    end

    assign PRDATA = rdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = slverr_q && PSEL && PENABLE;
    assign ACT_STATUS = act_status_q;
    assign CONTROLLER_SOFT_RESET = soft_reset_q;
    assign IRQ = irq_q;

endmodule

/* tb/ssc_chk.sv */
// assertions on the ports of the access config block
`timescale 1ns/1ps
module ssc_chk
    import ssc_pkg::*;
#(
    parameter int N_MODULES = MOD_CNT
)
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic LPC_REQ_VALID,
    input wire ssc_req_t LPC_REQ,
    input wire ssc_rsp_t LPC_RSP,
    input wire logic LPC_LONG_WAIT,
    input wire logic [N_MODULES-1:0] MODULE_LOCK,
    input wire logic [N_MODULES-1:0] FAST_DISABLE,
    input wire logic [N_MODULES-1:0] ACTIVATION_BIT,
    input wire logic [MOD_W-1:0] ACT_QUERY_MODULE,
    input wire logic ACT_STATUS,
    input wire logic CONTROLLER_SOFT_RESET
);
    logic [1:0] mode_q;
    logic act_q;
    wire wr = PSEL && PENABLE && PWRITE && PADDR == ADDR_CFG;
    wire rd = PSEL && PENABLE && !PWRITE && PADDR == ADDR_CFG;
    wire srst_wr = wr && PWDATA[7];
    wire tk = LPC_REQ_VALID && !LPC_LONG_WAIT;
    wire lk = MODULE_LOCK[LPC_REQ.module_id];
    wire hit = tk && lk;
    wire quiet = mode_q == 2'h1 || (mode_q == 2'h3 && !LPC_REQ.xcs);
    wire xwait = hit && mode_q == 2'h3 && LPC_REQ.xcs;
    wire [MOD_W-1:0] q = ACT_QUERY_MODULE;
    wire gone = MODULE_LOCK[q] | FAST_DISABLE[q];
    wire ax = ACTIVATION_BIT[q] & ~(act_q & gone);
    wire [31:0] cfg_rd = {26'h0, mode_q, 3'h0, act_q};
    // shadow of the configuration fields
    always_ff @(posedge CORE_CLK or posedge RST)
        if (RST)
            {mode_q, act_q} <= '0;
        else if (wr)
            {mode_q, act_q} <= {PWDATA[5:4], PWDATA[0]};
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    AST_SRST: assert property (srst_wr |=> CONTROLLER_SOFT_RESET)
        else $error("no soft reset pulse");
    AST_RD_CFG: assert property (rd |-> PRDATA == cfg_rd)
        else $error("bad config read");
    AST_ERR: assert property (hit && mode_q == 2'h0 |=>
        LPC_RSP.valid && LPC_RSP.sync == SYNC_ERROR && LPC_RSP.read_zero)
        else $error("no error sync");
    AST_QUIET: assert property (hit && quiet |=> LPC_RSP.valid
        && LPC_RSP.sync == SYNC_READY && LPC_RSP.read_zero
        && !LPC_RSP.forward)
        else $error("bad quiet answer");
    AST_IGN: assert property (hit && mode_q == 2'h2 |=>
        LPC_RSP.valid && LPC_RSP.sync == SYNC_NONE && !LPC_RSP.forward)
        else $error("locked cycle not ignored");
    AST_WAIT: assert property (xwait |=> LPC_LONG_WAIT && !LPC_RSP.valid)
        else $error("no long wait");
    AST_WAIT_END: assert property ($fell(LPC_LONG_WAIT) |->
        LPC_RSP.valid && LPC_RSP.sync == SYNC_READY && LPC_RSP.forward)
        else $error("long wait end without answer");
    AST_ACT: assert property (1'b1 |=> ACT_STATUS == $past(ax))
        else $error("bad activation status");
    cover property (LPC_LONG_WAIT ##1 !LPC_LONG_WAIT);
    cover property (CONTROLLER_SOFT_RESET);
    cover property (hit && mode_q == 2'h2);
endmodule
bind ssc_top ssc_chk #(.N_MODULES(N_MODULES)) chk_i
(
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .LPC_REQ_VALID(LPC_REQ_VALID),
    .LPC_REQ(LPC_REQ),
    .LPC_RSP(LPC_RSP),
    .LPC_LONG_WAIT(LPC_LONG_WAIT),
    .MODULE_LOCK(MODULE_LOCK),
    .FAST_DISABLE(FAST_DISABLE),
    .ACTIVATION_BIT(ACTIVATION_BIT),
    .ACT_QUERY_MODULE(ACT_QUERY_MODULE),
    .ACT_STATUS(ACT_STATUS),
    .CONTROLLER_SOFT_RESET(CONTROLLER_SOFT_RESET)
);

/* tb/ssc_lpc_host.sv */
// lpc host model issuing one cycle at a time
`timescale 1ns/1ps
module ssc_lpc_host
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [3:0] gap,
    input wire ssc_req_t req_in,
    input wire logic long_wait,
    output logic valid,
    output ssc_req_t req
);
    logic pend;
    logic [3:0] cnt;
    // a cycle waits out the gap and any long wait; idle request toggles
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            {pend, cnt, valid, req} <= '0;
        end
        else
        begin
            valid <= pend && cnt == 0 && !long_wait;
            if (!pend)
                req <= ~req;
            if (go)
            begin
                pend <= 1'b1;
                cnt <= gap;
                req <= req_in;
            end
            else if (cnt != 0)
                cnt <= cnt - 4'h1;
            else if (!long_wait)
                pend <= 1'b0;
        end
endmodule

/* tb/serial_side_access_config_tb.sv */
// self-checking bench of the access config block
`timescale 1ns/1ps
module serial_side_access_config_tb;
    import ssc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
    logic pready, pslverr, lv, lw, acts, srst, irq, err, c;
    logic [7:0] pa = 0, lk, f, a, lock = 0, fdis = 0, act = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic [2:0] qm = 0, q;
    logic [3:0] gap = 0;
    logic [1:0] m;
    ssc_req_t lrq, req = '0, r;
    ssc_rsp_t rsp, got, want;
    int seed = 37, error_cnt = 0, n_compared = 0;
    ssc_top dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(pready), .PSLVERR(pslverr), .LPC_REQ_VALID(lv),
        .LPC_REQ(lrq), .LPC_RSP(rsp), .LPC_LONG_WAIT(lw),
        .MODULE_LOCK(lock), .FAST_DISABLE(fdis), .ACTIVATION_BIT(act),
        .ACT_QUERY_MODULE(qm), .ACT_STATUS(acts),
        .CONTROLLER_SOFT_RESET(srst), .IRQ(irq));
    ssc_lpc_host host (.clk(clk), .rst(rst), .go(go), .gap(gap),
        .req_in(req), .long_wait(lw), .valid(lv), .req(lrq));
    initial forever #25 clk = ~clk;
    task automatic chk(logic [31:0] g, logic [31:0] e, string s);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h", $time, s, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, ad, d};
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prd;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic lpc(ssc_req_t x, logic [3:0] g);
        @(posedge clk);
        {req, gap, go} <= {x, g, 1'b1};
        @(posedge clk);
        go <= 0;
        repeat (40)
        begin
            @(posedge clk);
            if (rsp.valid || lw)
                break;
        end
        got = rsp;
    endtask
    function automatic ssc_rsp_t ex(logic [1:0] md, logic l);
        ex = '{1'b1, SYNC_READY, 1'b1, 1'b0};
        if (l)
            case (md)
                2'h0: ex = '{1'b1, SYNC_ERROR, 1'b0, 1'b1};
                2'h2: ex = '{1'b1, SYNC_NONE, 1'b0, 1'b0};
                default: ex = '{1'b1, SYNC_READY, 1'b0, 1'b1};
            endcase
    endfunction
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 0;
        apb(0, ADDR_CFG, '0);
        chk(rd, '0, "cfg");
        apb(1, ADDR_CFG, 32'hFFFF_FFFF);
        @(posedge clk);
        chk(srst, 1, "srst");
        @(posedge clk);
        chk(srst, 0, "srst end");
        apb(0, ADDR_CFG, '0);
        chk(rd, 32'h0000_0031, "cfg rd");
        apb(0, ADDR_STATUS, '0);
        chk(rd, 32'h0000_0002, "srst event");
        apb(0, 8'h08, '0);
        chk(err, 1, "unmapped err");
        chk(rd, '0, "unmapped rd");
        $display("registers done");
        for (int i = 0; i < 40; i++)
        begin
            m = i[1:0];
            apb(1, ADDR_CFG, {26'h0, m, 4'h0});
            lk = 8'($random(seed));
            lock <= lk;
            r = 5'($random(seed));
            r.xcs = r.xcs & (m != 2'h3);
            lpc(r, 4'(i % 3));
            want = ex(m, lk[r.module_id]);
            chk(32'(got), 32'(want), "rsp");
        end
        apb(1, ADDR_CFG, 32'h0000_0030);
        lock <= 8'h04;
        lpc('{1'b1, 1'b1, 3'h2}, 0);
        repeat (5) @(posedge clk);
        chk({lw, rsp.valid}, 2'b10, "wait");
        lock <= 0;
        repeat (10)
        begin
            @(posedge clk);
            if (rsp.valid)
                break;
        end
        chk(lw, 0, "wait end");
        chk(32'(rsp), 32'(ex(0, 0)), "wait end rsp");
        $display("lock modes done");
        apb(1, ADDR_CLEAR, 3);
        apb(1, ADDR_ENABLE, 1);
        apb(0, ADDR_ENABLE, '0);
        chk(rd, 1, "enable rd");
        chk(irq, 0, "irq idle");
        lock <= 8'hFF;
        apb(1, ADDR_CFG, '0);
        lpc('{1'b0, 1'b0, 3'h5}, 0);
        repeat (2) @(posedge clk);
        chk(irq, 1, "irq");
        apb(0, ADDR_STATUS, '0);
        chk(rd, 1, "viol");
        apb(1, ADDR_ENABLE, 0);
        @(posedge clk);
        chk(irq, 0, "masked");
        apb(1, ADDR_CLEAR, 1);
        apb(0, ADDR_STATUS, '0);
        chk(rd, 0, "cleared");
        $display("interrupt done");
        for (int i = 0; i < 30; i++)
        begin
            c = i >= 15;
            if (i % 15 == 0)
                apb(1, ADDR_CFG, 32'(c));
            {lk, f, a, q} = 27'($random(seed));
            {lock, fdis, act, qm} <= {lk, f, a, q};
            repeat (2) @(posedge clk);
            chk(acts, a[q] & ~(c & (lk[q] | f[q])), "act");
        end
        $display("activation done");
        complete_run();
    end
endmodule
